// [hw/monlink_cfg.svh]
// constants for the monitor overflow and capture-event linkage block
`ifndef MONLINK_CFG_SVH
`define MONLINK_CFG_SVH
// register offsets (byte addresses, word aligned)
`define ADDR_STOR_CTL     8'h00
`define ADDR_STOR_FLT     8'h04
`define ADDR_STOR_CNT     8'h08
`define ADDR_STOR_CAPT    8'h0C
`define ADDR_BW_CTL       8'h10
`define ADDR_BW_FLT       8'h14
`define ADDR_BW_CNT       8'h18
`define ADDR_BW_CAPT      8'h1C
`define ADDR_BW_LCNT      8'h20
`define ADDR_BW_LCAPT     8'h24
`define ADDR_TRIG         8'h28
`define ADDR_STATUS       8'h2C
// control register fields
`define CTL_EN_BIT        0
`define CTL_LNKG_LO       8
`define CTL_LNKG_HI       10
`define CTL_CAPT_L_BIT    13
`define CTL_CEV_LO        16
`define CTL_CEV_HI        18
`define CTL_OFLW_EV_BIT   19
`define CTL_INTR_L_BIT    20
`define CTL_OFLOW_L_BIT   21
`define CTL_CAPT_BIT      23
`define CTL_FRZ_BIT       24
`define CTL_INTR_BIT      25
`define CTL_OFLOW_BIT     26
`define CTL_CRST_BIT      27
// count register fields
`define CNT_NOT_READY_FLAG_BIT      31
// filter register: secure space flag
`define FLT_SEC_BIT       0
// trigger register fields
`define TRIG_NOW_BIT      0
`define TRIG_ALL_BIT      1
`define TRIG_SEC_BIT      2
// capture event codes
`define EV_NONE           3'h0
`define EV_LOCAL          3'h7
`define EV_LINK_MAX       3'h6
`define CTL_RESET         32'h0000_0000
`endif

// [hw/monlink_pkg.sv]
// types shared by the monitor linkage block
package monlink_pkg;
  // one capture event as delivered to monitors
  typedef struct packed {
    logic [2:0] code;  // event number, zero means none
    logic       sec;   // reaches secure-space monitors
    logic       nsec;  // reaches non-secure-space monitors
  } cev_t;
  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
endpackage

// [hw/monitor_overflow_linkage.sv]
// two resource monitors with overflow handling and capture-event linkage
`timescale 1ns/1ps
`include "monlink_cfg.svh"

module monitor_overflow_linkage #(
  parameter int CW            = 31,   // counter width
  parameter int LW            = 44,   // long counter width
  parameter bit LINK_SUP      = 1'b1, // linkage support
  parameter bit CAPT_SUP      = 1'b1, // capture support
  parameter bit OCAPT_SUP     = 1'b1, // overflow capture support
  parameter bit LOCAL_EV_SUP  = 1'b1  // local capture event support
) (
  input  wire logic        CLK_IN,       // 125 MHz clock
  input  wire logic        RST_N_IN,     // async reset, active low
  input  wire logic [7:0]  ADDR_IN,      // register byte address
  input  wire logic [31:0] WDATA_IN,     // write data
  input  wire logic        WR_IN,        // write strobe
  input  wire logic        RD_IN,        // read strobe
  output logic      [31:0] RDATA_OUT,    // read data, cycle after read
  input  wire logic        STOR_EV_IN,   // storage monitor event pulse
  input  wire logic        BW_EV_IN,     // bandwidth monitor event pulse
  input  wire logic [2:0]  EXT_CEV_IN,   // external capture event code pin
  output logic             STOR_IRQ_OUT, // storage overflow interrupt level
  output logic             BW_IRQ_OUT    // bandwidth overflow interrupt level
);

  // decoded request, kept together
  monlink_pkg::bus_req_t req;
  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  function automatic logic hit_wr(input monlink_pkg::bus_req_t r,
                                  input logic [7:0] a);
    hit_wr = r.wr && (r.addr == a);
  endfunction

  // event matches a monitor: select non-zero, code equal, space reached
  function automatic logic ev_match(input monlink_pkg::cev_t e,
                                    input logic [2:0] sel,
                                    input logic sec);
    ev_match = (sel != `EV_NONE) && (e.code == sel)
               && (sec ? e.sec : e.nsec);
  endfunction

  // registers
  logic [31:0]   s_ctl_ff, b_ctl_ff;
  logic          s_sec_ff, b_sec_ff;
  logic [CW-1:0] s_cnt_ff, b_cnt_ff;
  logic [LW-1:0] l_cnt_ff;
  logic          s_not_ready_flag_ff, b_not_ready_flag_ff, l_not_ready_flag_ff;
  logic [31:0]   s_capt_ff, b_capt_ff;
  logic [LW:0]   l_capt_ff;
  logic          s_frz_ff, b_frz_ff, l_frz_ff;
  logic [2:0]    ext_m_ff, ext_s_ff;
  logic          trig_now, trig_sec, trig_all;
  logic [31:0]   rdata_ff;
  logic          s_irq_ff, b_irq_ff;

  // external code pins cross in through two flops
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ext_m_ff <= `EV_NONE;
      ext_s_ff <= `EV_NONE;
    end else begin
      ext_m_ff <= EXT_CEV_IN;
      ext_s_ff <= ext_m_ff;
    end
  end

  // local trigger write: non-secure or secure, a secure one optionally to all spaces
  assign trig_now = hit_wr(req, `ADDR_TRIG) && req.wdata[`TRIG_NOW_BIT]
                    && LOCAL_EV_SUP;
  assign trig_sec = req.wdata[`TRIG_SEC_BIT];
  assign trig_all = req.wdata[`TRIG_ALL_BIT];

  // ---- overflow detection from increments
  logic s_inc, b_inc, l_inc;
  logic s_carry, b_carry, l_carry;
  logic [CW-1:0] s_sum, b_sum;
  logic [LW-1:0] l_sum;
  logic s_en, b_en;
  assign s_en = s_ctl_ff[`CTL_EN_BIT];
  assign b_en = b_ctl_ff[`CTL_EN_BIT];
  // frozen instances take no events
  assign s_inc = STOR_EV_IN && s_en && !s_frz_ff;
  assign b_inc = BW_EV_IN && b_en && !b_frz_ff;
  assign l_inc = BW_EV_IN && b_en && !l_frz_ff;
  // carry out of the top bit flags overflow, sum wraps
  assign {s_carry, s_sum} = {1'b0, s_cnt_ff} + {{CW{1'b0}}, s_inc};
  assign {b_carry, b_sum} = {1'b0, b_cnt_ff} + {{CW{1'b0}}, b_inc};
  assign {l_carry, l_sum} = {1'b0, l_cnt_ff} + {{LW{1'b0}}, l_inc};

  logic s_ovf, b_ovf, l_ovf;
  assign s_ovf = s_inc && s_carry;
  assign b_ovf = b_inc && b_carry;
  assign l_ovf = l_inc && l_carry;

  // ---- link broadcasts, gated by support, code and irq enable
  logic s_lnk, b_lnk, bl_lnk;
  logic [2:0] s_lc, b_lc;
  assign s_lc = s_ctl_ff[`CTL_LNKG_HI:`CTL_LNKG_LO];
  assign b_lc = b_ctl_ff[`CTL_LNKG_HI:`CTL_LNKG_LO];
  // code 7 is the local event, so only 1..6 are linkage codes
  assign s_lnk = LINK_SUP && s_ovf && (s_lc != `EV_NONE)
                 && (s_lc <= `EV_LINK_MAX)
                 && s_ctl_ff[`CTL_INTR_BIT];
  assign b_lnk = LINK_SUP && b_ovf && (b_lc != `EV_NONE)
                 && (b_lc <= `EV_LINK_MAX)
                 && b_ctl_ff[`CTL_INTR_BIT];
  assign bl_lnk = LINK_SUP && l_ovf && (b_lc != `EV_NONE)
                  && (b_lc <= `EV_LINK_MAX)
                  && b_ctl_ff[`CTL_INTR_L_BIT];

  // ---- event sources; events stay inside this component, no output
  monlink_pkg::cev_t ev_ext, ev_loc, ev_s, ev_b;
  // external reaches every space
  assign ev_ext = '{code: ext_s_ff, sec: 1'b1, nsec: 1'b1};
  // local reaches writer's space, secure with all bit reaches both
  assign ev_loc = '{code: trig_now ? `EV_LOCAL : `EV_NONE,
                    sec: trig_sec,
                    nsec: !trig_sec || trig_all};
  // link events reach only the originator's space
  assign ev_s = '{code: s_lnk ? s_lc : `EV_NONE,
                  sec: s_sec_ff, nsec: !s_sec_ff};
  assign ev_b = '{code: (b_lnk || bl_lnk) ? b_lc : `EV_NONE,
                  sec: b_sec_ff, nsec: !b_sec_ff};

  // each monitor hears events of the others and external/local
  logic s_hit, b_hit;
  assign s_hit = ev_match(ev_ext, s_ctl_ff[`CTL_CEV_HI:`CTL_CEV_LO], s_sec_ff)
              || ev_match(ev_loc, s_ctl_ff[`CTL_CEV_HI:`CTL_CEV_LO], s_sec_ff)
              || ev_match(ev_b, s_ctl_ff[`CTL_CEV_HI:`CTL_CEV_LO], s_sec_ff);
  assign b_hit = ev_match(ev_ext, b_ctl_ff[`CTL_CEV_HI:`CTL_CEV_LO], b_sec_ff)
              || ev_match(ev_loc, b_ctl_ff[`CTL_CEV_HI:`CTL_CEV_LO], b_sec_ff)
              || ev_match(ev_s, b_ctl_ff[`CTL_CEV_HI:`CTL_CEV_LO], b_sec_ff);

  // linked overflow: hit with event-as-overflow set
  logic s_lov, b_lov;
  assign s_lov = s_hit && s_ctl_ff[`CTL_OFLW_EV_BIT];
  assign b_lov = b_hit && b_ctl_ff[`CTL_OFLW_EV_BIT];

  // capture decision: plain capture on event, or on overflow if enabled
  logic s_cap, b_cap, l_cap;
  assign s_cap = CAPT_SUP && ((s_hit && !s_lov) ||
                 (OCAPT_SUP && s_ctl_ff[`CTL_CAPT_BIT]
                  && (s_ovf || s_lov)));
  assign b_cap = CAPT_SUP && ((b_hit && !b_lov) ||
                 (OCAPT_SUP && b_ctl_ff[`CTL_CAPT_BIT]
                  && (b_ovf || b_lov)));
  assign l_cap = CAPT_SUP && ((b_hit && !b_lov) ||
                 (OCAPT_SUP && b_ctl_ff[`CTL_CAPT_L_BIT]
                  && (l_ovf || b_lov)));

  // freeze decision; without capture a plain hit freezes s and b, not the long half, if not overflowed
  logic s_fz, b_fz, l_fz;
  assign s_fz = s_ctl_ff[`CTL_FRZ_BIT] && (s_ovf || s_lov ||
                (!CAPT_SUP && s_hit && !s_ctl_ff[`CTL_OFLOW_BIT]));
  assign b_fz = b_ctl_ff[`CTL_FRZ_BIT] && (b_ovf || b_lov ||
                (!CAPT_SUP && b_hit && !b_ctl_ff[`CTL_OFLOW_BIT]));
  assign l_fz = b_ctl_ff[`CTL_FRZ_BIT] && (l_ovf || b_lov);

  // flag clears by software
  logic s_ctl_wr, b_ctl_wr, s_cnt_wr, b_cnt_wr, l_cnt_wr;
  assign s_ctl_wr = hit_wr(req, `ADDR_STOR_CTL);
  assign b_ctl_wr = hit_wr(req, `ADDR_BW_CTL);
  assign s_cnt_wr = hit_wr(req, `ADDR_STOR_CNT);
  assign b_cnt_wr = hit_wr(req, `ADDR_BW_CNT);
  assign l_cnt_wr = hit_wr(req, `ADDR_BW_LCNT);

  // storage control: flag set wins over any clear in the same cycle
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_ctl_ff <= `CTL_RESET;
      s_sec_ff <= 1'b0;
    end else begin
      if (s_ctl_wr) begin
        s_ctl_ff <= req.wdata;
      end else if (s_cnt_wr) begin
        s_ctl_ff[`CTL_OFLOW_BIT] <= 1'b0;
      end
      if (s_ovf || s_lov) begin
        s_ctl_ff[`CTL_OFLOW_BIT] <= 1'b1;
      end
      if (hit_wr(req, `ADDR_STOR_FLT)) begin
        s_sec_ff <= req.wdata[`FLT_SEC_BIT];
      end
    end
  end

  // bandwidth control; long flag kept in its own bit
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      b_ctl_ff <= `CTL_RESET;
      b_sec_ff <= 1'b0;
    end else begin
      if (b_ctl_wr) begin
        b_ctl_ff <= req.wdata;
      end else begin
        if (b_cnt_wr) begin
          b_ctl_ff[`CTL_OFLOW_BIT] <= 1'b0;
        end
        if (l_cnt_wr) begin
          b_ctl_ff[`CTL_OFLOW_L_BIT] <= 1'b0;
        end
      end
      if (b_ovf || b_lov) begin
        b_ctl_ff[`CTL_OFLOW_BIT] <= 1'b1;
      end
      if (l_ovf || b_lov) begin
        b_ctl_ff[`CTL_OFLOW_L_BIT] <= 1'b1;
      end
      if (hit_wr(req, `ADDR_BW_FLT)) begin
        b_sec_ff <= req.wdata[`FLT_SEC_BIT];
      end
    end
  end

  // freeze state: set on freeze cause, cleared by flag clear or value write
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_frz_ff <= 1'b0;
      b_frz_ff <= 1'b0;
      l_frz_ff <= 1'b0;
    end else begin
      if (s_fz) begin
        s_frz_ff <= 1'b1;
      end else if (s_cnt_wr ||
                   (s_ctl_wr && !req.wdata[`CTL_OFLOW_BIT])) begin
        s_frz_ff <= 1'b0;
      end
      if (b_fz) begin
        b_frz_ff <= 1'b1;
      end else if (b_cnt_wr ||
                   (b_ctl_wr && !req.wdata[`CTL_OFLOW_BIT])) begin
        b_frz_ff <= 1'b0;
      end
      // long half needs its own write to thaw
      if (l_fz) begin
        l_frz_ff <= 1'b1;
      end else if (l_cnt_wr ||
                   (b_ctl_wr && !req.wdata[`CTL_OFLOW_L_BIT])) begin
        l_frz_ff <= 1'b0;
      end
    end
  end

  // counters: software write first, then clear-after-capture, then count
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_cnt_ff  <= '0;
      b_cnt_ff  <= '0;
      l_cnt_ff  <= '0;
      s_not_ready_flag_ff <= 1'b0;
      b_not_ready_flag_ff <= 1'b0;
      l_not_ready_flag_ff <= 1'b0;
    end else begin
      if (s_cnt_wr) begin
        s_cnt_ff  <= req.wdata[CW-1:0];
        s_not_ready_flag_ff <= req.wdata[`CNT_NOT_READY_FLAG_BIT];
      end else if (s_cap && s_ctl_ff[`CTL_CRST_BIT]) begin
        s_cnt_ff  <= '0;
        s_not_ready_flag_ff <= 1'b0;
      end else if (!s_frz_ff) begin
        s_cnt_ff  <= s_sum;
      end
      if (b_cnt_wr) begin
        b_cnt_ff  <= req.wdata[CW-1:0];
        b_not_ready_flag_ff <= req.wdata[`CNT_NOT_READY_FLAG_BIT];
      end else if (b_cap && b_ctl_ff[`CTL_CRST_BIT]) begin
        b_cnt_ff  <= '0;
        b_not_ready_flag_ff <= 1'b0;
      end else if (!b_frz_ff) begin
        b_cnt_ff  <= b_sum;
      end
      // long counter is written through its low word only
      if (l_cnt_wr) begin
        l_cnt_ff  <= LW'(req.wdata[CW-1:0]);
        l_not_ready_flag_ff <= req.wdata[`CNT_NOT_READY_FLAG_BIT];
      end else if (l_cap && b_ctl_ff[`CTL_CRST_BIT]) begin
        l_cnt_ff  <= '0;
        l_not_ready_flag_ff <= 1'b0;
      end else if (!l_frz_ff) begin
        l_cnt_ff  <= l_sum;
      end
    end
  end

  // capture takes the value as it stands after this cycle's count, so an
  // overflow captures the wrapped value and a clear loses no count
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_capt_ff <= '0;
      b_capt_ff <= '0;
      l_capt_ff <= '0;
    end else begin
      if (s_cap) begin
        s_capt_ff <= {s_not_ready_flag_ff, s_sum};
      end
      if (b_cap) begin
        b_capt_ff <= {b_not_ready_flag_ff, b_sum};
      end
      if (l_cap) begin
        l_capt_ff <= {l_not_ready_flag_ff, l_sum};
      end
    end
  end

  // interrupt levels follow flag and enable, registered for a clean output
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_irq_ff <= 1'b0;
      b_irq_ff <= 1'b0;
    end else begin
      s_irq_ff <= s_ctl_ff[`CTL_OFLOW_BIT] && s_ctl_ff[`CTL_INTR_BIT];
      b_irq_ff <= (b_ctl_ff[`CTL_OFLOW_BIT] && b_ctl_ff[`CTL_INTR_BIT])
               || (b_ctl_ff[`CTL_OFLOW_L_BIT]
                   && b_ctl_ff[`CTL_INTR_L_BIT]);
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_ff <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        `ADDR_STOR_CTL:  rdata_ff <= s_ctl_ff;
        `ADDR_STOR_FLT:  rdata_ff <= {31'h0, s_sec_ff};
        `ADDR_STOR_CNT:  rdata_ff <= {s_not_ready_flag_ff, s_cnt_ff};
        `ADDR_STOR_CAPT: rdata_ff <= s_capt_ff;
        `ADDR_BW_CTL:    rdata_ff <= b_ctl_ff;
        `ADDR_BW_FLT:    rdata_ff <= {31'h0, b_sec_ff};
        `ADDR_BW_CNT:    rdata_ff <= {b_not_ready_flag_ff, b_cnt_ff};
        `ADDR_BW_CAPT:   rdata_ff <= b_capt_ff;
        `ADDR_BW_LCNT:   rdata_ff <= {l_not_ready_flag_ff, l_cnt_ff[CW-1:0]};
        `ADDR_BW_LCAPT:  rdata_ff <= {l_capt_ff[LW], l_capt_ff[CW-1:0]};
        `ADDR_STATUS:    rdata_ff <= {29'h0, l_frz_ff, b_frz_ff, s_frz_ff};
        default:         rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign RDATA_OUT    = rdata_ff;
  assign STOR_IRQ_OUT = s_irq_ff;
  assign BW_IRQ_OUT   = b_irq_ff;

endmodule

// [tb/monlink_chk.sv]
// port-level assertions for the monitor overflow linkage block
`timescale 1ns/1ps
`include "monlink_cfg.svh"

module monlink_chk (
  input wire logic        CLK_IN,       // block clock
  input wire logic        RST_N_IN,     // async reset, active low
  input wire logic [7:0]  ADDR_IN,      // register byte address
  input wire logic [31:0] WDATA_IN,     // write data
  input wire logic        WR_IN,        // write strobe
  input wire logic        RD_IN,        // read strobe
  input wire logic [31:0] RDATA_OUT,    // read data
  input wire logic        STOR_EV_IN,   // storage event pulse
  input wire logic        BW_EV_IN,     // bandwidth event pulse
  input wire logic [2:0]  EXT_CEV_IN,   // external capture event
  input wire logic        STOR_IRQ_OUT, // storage interrupt
  input wire logic        BW_IRQ_OUT    // bandwidth interrupt
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // software writes that may legally drop the storage flag
  logic stor_wr;
  logic no_ev;
  assign stor_wr = WR_IN && (ADDR_IN == `ADDR_STOR_CTL ||
                             ADDR_IN == `ADDR_STOR_CNT);
  // an overflow in the same cycle wins over a clear, so leave it out
  assign no_ev = !STOR_EV_IN && !BW_EV_IN;

  rdata_idle_a: assert property (
    !$past(RD_IN) |-> RDATA_OUT == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (
    RD_IN && ADDR_IN > `ADDR_STATUS |=> RDATA_OUT == 32'h0000_0000)
    else $error("unmapped read returned data");
  reset_quiet_a: assert property (
    $rose(RST_N_IN) |-> !STOR_IRQ_OUT && !BW_IRQ_OUT)
    else $error("interrupt high right after reset");
  stor_cnt_clear_a: assert property (
    WR_IN && ADDR_IN == `ADDR_STOR_CNT && no_ev |-> ##2 !STOR_IRQ_OUT)
    else $error("storage count write left interrupt high");
  bw_cnt_clear_a: assert property (
    WR_IN && ADDR_IN == `ADDR_BW_CNT && no_ev |-> ##2 !BW_IRQ_OUT)
    else $error("bandwidth count write left interrupt high");
  flag_write_clear_a: assert property (
    WR_IN && ADDR_IN == `ADDR_STOR_CTL && !WDATA_IN[`CTL_OFLOW_BIT] &&
    no_ev |-> ##2 !STOR_IRQ_OUT)
    else $error("control write with flag zero left interrupt high");
  irq_set_a: assert property (
    WR_IN && ADDR_IN == `ADDR_STOR_CTL && WDATA_IN[`CTL_OFLOW_BIT] &&
    WDATA_IN[`CTL_INTR_BIT] |-> ##2 STOR_IRQ_OUT)
    else $error("flag with enable did not raise interrupt");
  irq_mask_a: assert property (
    WR_IN && ADDR_IN == `ADDR_BW_CTL && !WDATA_IN[`CTL_INTR_BIT] &&
    !WDATA_IN[`CTL_INTR_L_BIT] |-> ##2 !BW_IRQ_OUT)
    else $error("disabled interrupt still high");
  irq_sticky_a: assert property (
    $fell(STOR_IRQ_OUT) |-> $past(stor_wr, 2))
    else $error("interrupt dropped without a software write");
endmodule

bind monitor_overflow_linkage monlink_chk u_chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .STOR_EV_IN(STOR_EV_IN), .BW_EV_IN(BW_EV_IN),
  .EXT_CEV_IN(EXT_CEV_IN), .STOR_IRQ_OUT(STOR_IRQ_OUT),
  .BW_IRQ_OUT(BW_IRQ_OUT));

// [tb/tb_top.sv]
// self-checking bench for the monitor overflow linkage block
`timescale 1ns/1ps
`include "monlink_cfg.svh"

`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("Error %s exp %h got %h", n, e, g); \
  end \
end

module tb_top;
  localparam logic [31:0] en_bit = 32'h0000_0001;
  localparam logic [31:0] ie_bit = 32'h0200_0000;
  localparam logic [31:0] fl_bit = 32'h0400_0000;
  localparam logic [31:0] fz_bit = 32'h0100_0000;
  localparam logic [31:0] cp_bit = 32'h0080_0000;
  localparam logic [31:0] cr_bit = 32'h0800_0000;
  localparam logic [31:0] eo_bit = 32'h0008_0000;
  localparam logic [31:0] cl_bit = 32'h0000_2000;
  localparam logic [31:0] msk    = 32'h7FFF_FFFF;
  localparam logic [31:0] all1   = 32'hFFFF_FFFF;

  logic        CLK_IN = 1'b0;
  logic        RST_N_IN = 1'b0;
  logic [7:0]  ADDR_IN = 8'h00;
  logic [31:0] WDATA_IN = 32'h0000_0000;
  logic        WR_IN = 1'b0;
  logic        RD_IN = 1'b0;
  logic [31:0] RDATA_OUT;
  logic        STOR_EV_IN = 1'b0;
  logic        BW_EV_IN = 1'b0;
  logic [2:0]  EXT_CEV_IN = 3'h0;
  logic        STOR_IRQ_OUT;
  logic        BW_IRQ_OUT;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  logic        rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  adr_q[$];
  logic [31:0] v;
  int          n;

  monitor_overflow_linkage dut (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .STOR_EV_IN(STOR_EV_IN), .BW_EV_IN(BW_EV_IN),
    .EXT_CEV_IN(EXT_CEV_IN), .STOR_IRQ_OUT(STOR_IRQ_OUT),
    .BW_IRQ_OUT(BW_IRQ_OUT));

  always #4 CLK_IN = ~CLK_IN;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang would otherwise stall the run, the tests need a few hundred
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // read data stands only in the cycle after the strobe, compare it there
  always @(posedge CLK_IN) begin
    if (rd_pend) begin
      checked++;
      if ((RDATA_OUT & msk_q[0]) !== exp_q[0]) begin
        error_cnt++;
        $display("Error rdata_%h exp %h got %h", adr_q[0], exp_q[0],
                 RDATA_OUT & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(adr_q.pop_front());
    end
    rd_pend <= RD_IN;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    ADDR_IN  <= a;
    WDATA_IN <= d;
    WR_IN    <= 1'b1;
    @(posedge CLK_IN);
    WR_IN    <= 1'b0;
  endtask

  // the expected word is noted when the read is issued
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN   <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    adr_q.push_back(a);
    @(posedge CLK_IN);
    RD_IN   <= 1'b0;
  endtask

  task automatic ev(input logic [1:0] s, input int cnt);
    repeat (cnt) begin
      @(posedge CLK_IN);
      {BW_EV_IN, STOR_EV_IN} <= s;
    end
    @(posedge CLK_IN);
    {BW_EV_IN, STOR_EV_IN} <= 2'b00;
  endtask

  // one-cycle external code, then let the input synchroniser drain
  task automatic cev(input logic [2:0] c);
    @(posedge CLK_IN);
    EXT_CEV_IN <= c;
    @(posedge CLK_IN);
    EXT_CEV_IN <= 3'h0;
    repeat (4) @(posedge CLK_IN);
  endtask

  initial begin
    void'($urandom(29187));
    repeat (10) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    rd(`ADDR_STOR_CTL, `CTL_RESET, all1);
    rd(8'h40, 32'h0000_0000, all1);
    // own overflow: flag, interrupt, wrap, flag sticks until software
    wr(`ADDR_STOR_CTL, en_bit | ie_bit);
    wr(`ADDR_STOR_CNT, msk);
    ev(2'b01, 1);
    rd(`ADDR_STOR_CTL, en_bit | ie_bit | fl_bit, all1);
    `CHK("stor_irq", 1'b1, STOR_IRQ_OUT)
    rd(`ADDR_STOR_CNT, 32'h0000_0000, msk);
    n = $urandom_range(2, 9);
    ev(2'b01, n);
    rd(`ADDR_STOR_CTL, en_bit | ie_bit | fl_bit, all1);
    rd(`ADDR_STOR_CNT, 32'(n), msk);
    wr(`ADDR_STOR_CNT, 32'h0000_0000);
    rd(`ADDR_STOR_CTL, en_bit | ie_bit, all1);
    `CHK("stor_irq", 1'b0, STOR_IRQ_OUT)
    wr(`ADDR_STOR_CTL, en_bit | fl_bit);
    repeat (2) @(posedge CLK_IN);
    `CHK("stor_irq", 1'b0, STOR_IRQ_OUT)
    wr(`ADDR_STOR_CTL, en_bit | ie_bit | fl_bit);
    repeat (2) @(posedge CLK_IN);
    `CHK("stor_irq", 1'b1, STOR_IRQ_OUT)
    // every link code carries a bandwidth overflow to the storage monitor
    for (int k = 1; k <= 6; k++) begin
      v = $urandom_range(1, 500);
      wr(`ADDR_BW_CTL, en_bit | ie_bit | (32'(k) << `CTL_LNKG_LO));
      wr(`ADDR_BW_CNT, msk);
      wr(`ADDR_STOR_CTL, en_bit | cr_bit | (32'(k) << `CTL_CEV_LO));
      wr(`ADDR_STOR_CNT, v);
      ev(2'b10, 1);
      rd(`ADDR_STOR_CAPT, v, msk);
      rd(`ADDR_STOR_CNT, 32'h0000_0000, msk);
      `CHK("bw_irq", 1'b1, BW_IRQ_OUT)
      wr(`ADDR_BW_CNT, 32'h0000_0000);
    end
    // no broadcast without irq enable, no response with select zero
    for (int j = 0; j < 2; j++) begin
      wr(`ADDR_BW_CTL, en_bit | ((j != 0) ? ie_bit : 32'h0000_0000) |
         (32'h1 << `CTL_LNKG_LO));
      wr(`ADDR_STOR_CTL, en_bit | cr_bit |
         ((j != 0) ? 32'h0000_0000 : (32'h1 << `CTL_CEV_LO)));
      wr(`ADDR_STOR_CNT, 32'h0000_004D);
      wr(`ADDR_BW_CNT, msk);
      ev(2'b10, 1);
      rd(`ADDR_STOR_CNT, 32'h0000_004D, msk);
      wr(`ADDR_BW_CNT, 32'h0000_0000);
    end
    // external event taken as overflow by a secure monitor: freeze, capture
    wr(`ADDR_STOR_FLT, 32'h0000_0001);
    wr(`ADDR_STOR_CTL, en_bit | cp_bit | fz_bit | eo_bit |
       (32'h5 << `CTL_CEV_LO));
    wr(`ADDR_STOR_CNT, 32'h0000_0003);
    cev(3'h5);
    ev(2'b01, 4);
    rd(`ADDR_STOR_CNT, 32'h0000_0003, msk);
    rd(`ADDR_STOR_CAPT, 32'h0000_0003, msk);
    wr(`ADDR_STOR_CNT, 32'h0000_000A);
    ev(2'b01, 2);
    rd(`ADDR_STOR_CNT, 32'h0000_000C, msk);
    // local trigger reaches monitors of the writer's space, or both spaces with the all bit on a secure write
    wr(`ADDR_STOR_CTL, en_bit | (32'h7 << `CTL_CEV_LO));
    wr(`ADDR_STOR_CNT, 32'h0000_0014);
    wr(`ADDR_TRIG, 32'h0000_0001);
    rd(`ADDR_STOR_CAPT, 32'h0000_0003, msk);
    wr(`ADDR_TRIG, 32'h0000_0005);
    rd(`ADDR_STOR_CAPT, 32'h0000_0014, msk);
    wr(`ADDR_STOR_FLT, 32'h0000_0000);
    wr(`ADDR_STOR_CNT, 32'h0000_0015);
    wr(`ADDR_TRIG, 32'h0000_0007);
    rd(`ADDR_STOR_CAPT, 32'h0000_0015, msk);
    // own overflow freezes and captures, its link freezes both bandwidth
    // halves, and a short-half count write thaws the short half only, not the long one
    wr(`ADDR_STOR_CTL, en_bit | ie_bit | fz_bit | cp_bit |
       (32'h3 << `CTL_LNKG_LO));
    wr(`ADDR_BW_CTL, en_bit | eo_bit | fz_bit | cp_bit | cl_bit |
       (32'h3 << `CTL_CEV_LO));
    wr(`ADDR_BW_CNT, 32'h0000_0022);
    wr(`ADDR_BW_LCNT, 32'h0000_0033);
    wr(`ADDR_STOR_CNT, msk);
    ev(2'b01, 1);
    ev(2'b11, 3);
    rd(`ADDR_STOR_CNT, 32'h0000_0000, msk);
    rd(`ADDR_STOR_CAPT, 32'h0000_0000, msk);
    rd(`ADDR_BW_CAPT, 32'h0000_0022, msk);
    rd(`ADDR_BW_LCAPT, 32'h0000_0033, msk);
    rd(`ADDR_STATUS, 32'h0000_0007, all1);
    `CHK("stor_irq", 1'b1, STOR_IRQ_OUT)
    wr(`ADDR_BW_CNT, 32'h0000_0040);
    ev(2'b10, 2);
    rd(`ADDR_BW_CNT, 32'h0000_0042, msk);
    rd(`ADDR_BW_LCNT, 32'h0000_0033, msk);
    rd(`ADDR_STATUS, 32'h0000_0005, all1);
    repeat (4) @(posedge CLK_IN);
    test_done();
  end
endmodule
